/* File: hw/qsw_device.sv */
// Device end: quad address/data register write receiver
`timescale 1ns/1ps
// ========================================
// Overview of operation
// - Command one bit, then four bits per clock
// - Single write command (E2h) only, up to 80 MHz
// - Chip select low, command E2h on line 0
// - Two address bytes on four lines
// - Address is a byte address
// - Data starts with high nibble of byte 0
// - Write only after full 32-bit word
// - Early deselect discards partial word
// - Host ends transfer by raising select
// ========================================
module qsw_device
    import qsw_pkg::*;
(
    input  wire logic                 i_ref_clk,
    input  wire logic                 i_reset_n,
    qsw_if.device                     link,
    output logic                      o_wr_valid,
    output logic [qsw_pkg::ADDR_BITS-1:0] o_wr_addr,
    output logic [qsw_pkg::DATA_BITS-1:0] o_wr_data,
    output logic                      o_cmd_reject
);
    import qsw_pkg::*;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_CMD  = 4'b0010,
        ST_ADDR = 4'b0100,
        ST_DATA = 4'b1000
    } qsw_dev_state_t;

    // ========================================
    // Pin synchronisers
    // ========================================
    // Three stages; a clock or select change counts once stages two and three agree
    logic [5:0] sync1_r;
    logic [5:0] sync2_r;
    logic [5:0] sync3_r;
    logic       sclk_q_r;
    logic       cs_q_r;
    logic [5:0] sync_nxt;
    logic       sclk_nxt;
    logic       cs_nxt;

    always_comb
    begin
        sync_nxt = {link.sclk, link.chip_select_n, link.serial_io_lines};
        sclk_nxt = (sync2_r[5] == sync3_r[5]) ? sync3_r[5] : sclk_q_r;
        cs_nxt   = (sync2_r[4] == sync3_r[4]) ? sync3_r[4] : cs_q_r;
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_reset_n)
        begin
            // Clock bit rests low like its pin, so no false edge on exit
            sync1_r  <= 6'h1F;
            sync2_r  <= 6'h1F;
            sync3_r  <= 6'h1F;
            sclk_q_r <= 1'b0;
            cs_q_r   <= 1'b1;
        end
        else
        begin
            sync1_r  <= sync_nxt;
            sync2_r  <= sync1_r;
            sync3_r  <= sync2_r;
            sclk_q_r <= sclk_nxt;
            cs_q_r   <= cs_nxt;
        end
    end

    // Rising serial edge; lines were set up half a period earlier
    logic       sclk_rise;
    logic [3:0] lines;
    assign sclk_rise = sclk_nxt & ~sclk_q_r;
    assign lines     = sync3_r[3:0];

    // ========================================
    // Receive state machine
    // ========================================
    qsw_dev_state_t           state_r;
    qsw_dev_state_t           state_nxt;
    logic [2:0]               cnt_r;
    logic [2:0]               cnt_nxt;
    logic [7:0]               cmd_r;
    logic [7:0]               cmd_nxt;
    logic [ADDR_BITS-1:0]     addr_r;
    logic [ADDR_BITS-1:0]     addr_nxt;
    logic [DATA_BITS-1:0]     shift_r;
    logic [DATA_BITS-1:0]     shift_nxt;
    logic                     wr_valid_nxt;
    logic [ADDR_BITS-1:0]     wr_addr_nxt;
    logic [DATA_BITS-1:0]     wr_data_nxt;
    logic                     reject_nxt;
    logic [DATA_BITS-1:0]     word;

    // Nibble order within the word: high nibble of byte 0 first
    function automatic logic [DATA_BITS-1:0] byte_swap
        (input logic [DATA_BITS-1:0] v);
        byte_swap = {v[7:0], v[15:8], v[23:16], v[31:24]};
    endfunction

    always_comb
    begin
        state_nxt    = state_r;
        cnt_nxt      = cnt_r;
        cmd_nxt      = cmd_r;
        addr_nxt     = addr_r;
        shift_nxt    = shift_r;
        wr_valid_nxt = 1'b0;
        wr_addr_nxt  = o_wr_addr;
        wr_data_nxt  = o_wr_data;
        reject_nxt   = 1'b0;
        word         = byte_swap({shift_r[DATA_BITS-5:0], lines});
        if (cs_q_r)
        begin
            // Deselect ends the cycle; partial word is dropped
            state_nxt = ST_IDLE;
        end
        else
        begin
            case (state_r)
                ST_IDLE:
                begin
                    state_nxt = ST_CMD;
                    cnt_nxt   = 3'h0;
                end
                ST_CMD:
                begin
                    if (sclk_rise)
                    begin
                        cmd_nxt = {cmd_r[6:0], lines[0]};
                        cnt_nxt = cnt_r + 3'h1;
                        if (cnt_r == 3'h7)
                        begin
                            cnt_nxt = 3'h0;
                            // Only the single-line framing is decoded
                            if ({cmd_r[6:0], lines[0]} ==
                                QUAD_ADDR_DATA_WRITE_CMD)
                                state_nxt = ST_ADDR;
                            else
                            begin
                                // Other commands: ignore rest of frame
                                state_nxt  = ST_DATA;
                                reject_nxt = 1'b1;
                            end
                        end
                    end
                end
                ST_ADDR:
                begin
                    if (sclk_rise)
                    begin
                        addr_nxt = {addr_r[ADDR_BITS-5:0], lines};
                        cnt_nxt  = cnt_r + 3'h1;
                        if (cnt_r == 3'(ADDR_NIBBLES - 1))
                        begin
                            cnt_nxt   = 3'h0;
                            state_nxt = ST_DATA;
                        end
                    end
                end
                ST_DATA:
                begin
                    if (sclk_rise && (cmd_r == QUAD_ADDR_DATA_WRITE_CMD))
                    begin
                        shift_nxt = {shift_r[DATA_BITS-5:0], lines};
                        cnt_nxt   = cnt_r + 3'h1;
                        if (cnt_r == 3'(DATA_NIBBLES - 1))
                        begin
                            // Commit only on a whole word
                            wr_valid_nxt = 1'b1;
                            wr_addr_nxt  = addr_r;
                            wr_data_nxt  = word;
                            addr_nxt     = addr_r + ADDR_STEP;
                            cnt_nxt      = 3'h0;
                        end
                    end
                end
                default:
                begin
                    state_nxt = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_reset_n)
        begin
            state_r      <= ST_IDLE;
            cnt_r        <= 3'h0;
            cmd_r        <= 8'h00;
            addr_r       <= 16'h0000;
            shift_r      <= 32'h00000000;
            o_wr_valid   <= 1'b0;
            o_wr_addr    <= 16'h0000;
            o_wr_data    <= 32'h00000000;
            o_cmd_reject <= 1'b0;
        end
        else
        begin
            state_r      <= state_nxt;
            cnt_r        <= cnt_nxt;
            cmd_r        <= cmd_nxt;
            addr_r       <= addr_nxt;
            shift_r      <= shift_nxt;
            o_wr_valid   <= wr_valid_nxt;
            o_wr_addr    <= wr_addr_nxt;
            o_wr_data    <= wr_data_nxt;
            o_cmd_reject <= reject_nxt;
        end
    end
endmodule : qsw_device

/* File: hw/qsw_pkg.sv */
// Package: constants shared by the quad register write serial ends
package qsw_pkg;
    // ========================================
    // Command and framing
    // ========================================
    localparam logic [7:0]  QUAD_ADDR_DATA_WRITE_CMD = 8'hE2;
    localparam int          CMD_BITS                 = 8;
    localparam int          ADDR_BITS                = 16;
    localparam int          DATA_BITS                = 32;
    localparam int          ADDR_NIBBLES             = ADDR_BITS / 4;
    localparam int          DATA_NIBBLES             = DATA_BITS / 4;
    localparam logic [15:0] ADDR_STEP                = 16'h0004;
    // ========================================
    // Timing
    // ========================================
    localparam int          REF_CLK_MHZ              = 125;
    localparam int          MAX_SCLK_MHZ             = 80;
    localparam int          MIN_CS_HIGH_NS           = 50;
    localparam int          MIN_CS_HIGH_CYC          =
        (MIN_CS_HIGH_NS * REF_CLK_MHZ + 999) / 1000;
    // Host serial clock half period in reference clocks
    localparam int          HOST_HALF_PERIOD_CYC     = 8;
endpackage : qsw_pkg

/* File: hw/qsw_if.sv */
// Interface: serial link between host and device ends
`timescale 1ns/1ps
interface qsw_if;
    logic       sclk;
    logic       chip_select_n;
    logic [3:0] sio_out;
    logic [3:0] sio_oe;
    logic [3:0] serial_io_lines;
    // Lines resolved from the host enables; undriven lines read high
    assign serial_io_lines = sio_out | ~sio_oe;
    modport host   (output sclk, output chip_select_n,
                    output sio_out, output sio_oe);
    modport device (input sclk, input chip_select_n,
                    input serial_io_lines);
endinterface : qsw_if

/* File: hw/qsw_host.sv */
// Host end: issues quad address/data register writes
`timescale 1ns/1ps
module qsw_host
    import qsw_pkg::*;
#(
    parameter int HALF_CYC = qsw_pkg::HOST_HALF_PERIOD_CYC
)
(
    input  wire logic                 i_ref_clk,
    input  wire logic                 i_reset_n,
    input  wire logic                 i_start,
    input  wire logic [qsw_pkg::ADDR_BITS-1:0] i_addr,
    input  wire logic [qsw_pkg::DATA_BITS-1:0] i_data,
    input  wire logic [3:0]           i_words,
    qsw_if.host                       link,
    output logic                      o_busy,
    output logic                      o_done
);
    import qsw_pkg::*;

    // Serial rate must stay below the 80 MHz ceiling and be sampleable
    if (HALF_CYC < 4 || HALF_CYC > 255)
    begin : g_half_cyc_check
        $error("qsw_host: HALF_CYC out of range");
    end

    typedef enum logic [3:0] {
        HS_IDLE = 4'b0001,
        HS_SEL  = 4'b0010,
        HS_SHIFT = 4'b0100,
        HS_GAP  = 4'b1000
    } qsw_host_state_t;

    // ========================================
    // Shifter
    // ========================================
    // Frame: 8 command bits, 4 address nibbles, words x 8 data nibbles
    qsw_host_state_t state_r, state_nxt;
    logic [7:0]  div_r, div_nxt;
    logic [7:0]  step_r, step_nxt;
    logic [7:0]  total_r, total_nxt;
    logic [63:0] sh_r, sh_nxt;
    logic        sclk_nxt, cs_nxt, busy_nxt, done_nxt;
    logic [3:0]  out_nxt, oe_nxt;
    logic [DATA_BITS-1:0] data_r, data_nxt;

    function automatic logic [DATA_BITS-1:0] byte_swap
        (input logic [DATA_BITS-1:0] v);
        byte_swap = {v[7:0], v[15:8], v[23:16], v[31:24]};
    endfunction

    always_comb
    begin
        state_nxt = state_r;
        div_nxt = div_r;
        step_nxt = step_r;
        total_nxt = total_r;
        sh_nxt = sh_r;
        sclk_nxt = link.sclk;
        cs_nxt = link.chip_select_n;
        out_nxt = link.sio_out;
        oe_nxt = link.sio_oe;
        busy_nxt = o_busy;
        done_nxt = 1'b0;
        data_nxt = data_r;
        case (state_r)
            HS_IDLE:
            begin
                if (i_start && i_words != 4'h0)
                begin
                    cs_nxt = 1'b0;
                    busy_nxt = 1'b1;
                    sh_nxt = {8'h00, i_addr, byte_swap(i_data), 8'h00};
                    data_nxt = i_data;
                    total_nxt = 8'(CMD_BITS + ADDR_NIBBLES)
                        + 8'(DATA_NIBBLES) * {4'h0, i_words};
                    step_nxt = 8'h00;
                    div_nxt = 8'h00;
                    state_nxt = HS_SEL;
                end
            end
            HS_SEL, HS_SHIFT:
            begin
                div_nxt = div_r + 8'h01;
                if (div_r == 8'(HALF_CYC - 1))
                begin
                    div_nxt = 8'h00;
                    if (!link.sclk && state_r == HS_SHIFT)
                        sclk_nxt = 1'b1;
                    else if (step_r == total_r)
                    begin
                        sclk_nxt = 1'b0;
                        cs_nxt = 1'b1;
                        oe_nxt = 4'h0;
                        state_nxt = HS_GAP;
                    end
                    else
                    begin
                        // Drive next symbol on the low phase
                        sclk_nxt = 1'b0;
                        state_nxt = HS_SHIFT;
                        step_nxt = step_r + 8'h01;
                        if (step_r < 8'(CMD_BITS))
                        begin
                            out_nxt = {3'h0,
                                QUAD_ADDR_DATA_WRITE_CMD[3'(7 - step_r)]};
                            oe_nxt = 4'h1;
                        end
                        else
                        begin
                            out_nxt = sh_r[55:52];
                            oe_nxt = 4'hF;
                            sh_nxt = {sh_r[59:0], 4'h0};
                            // Reload the same word for the next register
                            if (step_r == 8'(CMD_BITS + ADDR_NIBBLES
                                + DATA_NIBBLES - 1)
                                || (step_r > 8'(CMD_BITS + ADDR_NIBBLES)
                                && ((step_r - 8'(CMD_BITS + ADDR_NIBBLES))
                                % 8'(DATA_NIBBLES)) == 8'(DATA_NIBBLES - 1)))
                                // Word must sit where the next nibble is taken
                                sh_nxt = {8'h00, byte_swap(data_r),
                                          24'h000000};
                        end
                    end
                end
            end
            HS_GAP:
            begin
                // Honour the least deselect time before the next frame
                div_nxt = div_r + 8'h01;
                if (div_r == 8'(MIN_CS_HIGH_CYC))
                begin
                    busy_nxt = 1'b0;
                    done_nxt = 1'b1;
                    state_nxt = HS_IDLE;
                end
            end
            default:
            begin
                state_nxt = HS_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_reset_n)
        begin
            state_r <= HS_IDLE;
            div_r <= 8'h00;
            step_r <= 8'h00;
            total_r <= 8'h00;
            sh_r <= 64'h0;
            data_r <= 32'h0;
            link.sclk <= 1'b0;
            link.chip_select_n <= 1'b1;
            link.sio_out <= 4'h0;
            link.sio_oe <= 4'h0;
            o_busy <= 1'b0;
            o_done <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            div_r <= div_nxt;
            step_r <= step_nxt;
            total_r <= total_nxt;
            sh_r <= sh_nxt;
            data_r <= data_nxt;
            link.sclk <= sclk_nxt;
            link.chip_select_n <= cs_nxt;
            link.sio_out <= out_nxt;
            link.sio_oe <= oe_nxt;
            o_busy <= busy_nxt;
            o_done <= done_nxt;
        end
    end
endmodule : qsw_host

/* File: verification/qsw_props.sv */
// Checker: assertions on the host to device quad write link
`timescale 1ns/1ps
module qsw_props
    import qsw_pkg::*;
(
    input wire logic                          i_ref_clk,
    input wire logic                          i_reset_n,
    input wire logic                          sclk,
    input wire logic                          chip_select_n,
    input wire logic [3:0]                    sio_oe,
    input wire logic [3:0]                    serial_io_lines,
    input wire logic                          o_wr_valid,
    input wire logic [qsw_pkg::ADDR_BITS-1:0] o_wr_addr,
    input wire logic [qsw_pkg::DATA_BITS-1:0] o_wr_data,
    input wire logic                          o_cmd_reject
);
    import qsw_pkg::*;
    // ==========
    // Rising edges per frame, kept past deselect for late write pulses
    logic        sclk_r, sclk_nxt, cs_n_r, cs_n_nxt, rise;
    logic        more_r, more_nxt;
    logic [7:0]  cnt_r, cnt_nxt;
    logic [15:0] last_r, last_nxt;
    always_comb
    begin
        rise     = sclk && !sclk_r;
        sclk_nxt = sclk;
        cs_n_nxt = chip_select_n;
        cnt_nxt  = cnt_r;
        more_nxt = more_r;
        last_nxt = last_r;
        if (cs_n_r && !chip_select_n)
        begin
            cnt_nxt  = 8'h00;
            more_nxt = 1'b0;
        end
        else if (rise && !chip_select_n)
            cnt_nxt = cnt_r + 8'h01;
        if (o_wr_valid)
        begin
            more_nxt = 1'b1;
            last_nxt = o_wr_addr;
        end
    end
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_reset_n)
        begin
            sclk_r <= 1'b0;
            cs_n_r <= 1'b1;
            cnt_r  <= 8'h00;
            more_r <= 1'b0;
            last_r <= 16'h0000;
        end
        else
        begin
            sclk_r <= sclk_nxt;
            cs_n_r <= cs_n_nxt;
            cnt_r  <= cnt_nxt;
            more_r <= more_nxt;
            last_r <= last_nxt;
        end
    end
    // ==========
    // Assertions
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_reset_n);
    sequence word_end_s;
        rise && !chip_select_n && cnt_r >= 8'h13 && cnt_r[2:0] == 3'h3;
    endsequence
    sequence on_boundary_s;
        cnt_r >= 8'h14 && cnt_r[2:0] == 3'h4;
    endsequence
    word_write_a: assert property (word_end_s |-> ##[1:8] o_wr_valid)
        else $error("no write after a full word");
    full_word_a: assert property (o_wr_valid |-> on_boundary_s)
        else $error("write before a full word");
    valid_pulse_a: assert property (o_wr_valid |=> !o_wr_valid)
        else $error("write pulse longer than one cycle");
    data_hold_a: assert property ($changed(o_wr_data) ||
        $changed(o_wr_addr) |-> o_wr_valid)
        else $error("write outputs moved without a write");
    addr_step_a: assert property (o_wr_valid && more_r |->
        o_wr_addr == last_r + ADDR_STEP)
        else $error("burst address not consecutive");
    cmd_line0_a: assert property (rise && !chip_select_n &&
        cnt_r < 8'h08 |-> sio_oe[0] &&
        serial_io_lines[0] == QUAD_ADDR_DATA_WRITE_CMD[3'h7 - cnt_r[2:0]])
        else $error("command bit wrong on line 0");
    quad_lines_a: assert property (rise && !chip_select_n &&
        cnt_r >= 8'h08 |-> sio_oe == 4'hF)
        else $error("address or data not on four lines");
    sclk_idle_a: assert property (chip_select_n |-> !sclk)
        else $error("serial clock moves while deselected");
    cs_gap_a: assert property ($rose(chip_select_n) |->
        chip_select_n [*7])
        else $error("deselect gap too short");
    frame_end_a: assert property ($rose(chip_select_n) |->
        on_boundary_s)
        else $error("frame ended inside a word");
    no_reject_a: assert property (!o_cmd_reject)
        else $error("valid command refused");
endmodule // qsw_props

/* File: verification/testbench.sv */
// Testbench: host and device ends face to face, plus a bench-driven link
`timescale 1ns/1ps
module testbench;
    import qsw_pkg::*;
    logic        ref_clk, reset_n, start, busy, done;
    logic [15:0] addr, waddr_a, waddr_b;
    logic [31:0] data, wdata_a, wdata_b;
    logic [3:0]  words;
    logic        valid_a, rej_a, valid_b, rej_b;
    logic [47:0] got_a[$];
    logic [47:0] got_b[$];
    int          rej_cnt, fail_count, total_checks;
    logic [7:0]  bad_cmd[5] = '{8'hE3, 8'h62, 8'hB2, 8'h00, 8'hC2};
    qsw_if link_a();
    qsw_if link_b();
    qsw_host i_qsw_host (.i_ref_clk(ref_clk), .i_reset_n(reset_n),
        .i_start(start), .i_addr(addr), .i_data(data), .i_words(words),
        .link(link_a), .o_busy(busy), .o_done(done));
    qsw_device i_qsw_device (.i_ref_clk(ref_clk), .i_reset_n(reset_n),
        .link(link_a), .o_wr_valid(valid_a), .o_wr_addr(waddr_a),
        .o_wr_data(wdata_a), .o_cmd_reject(rej_a));
    // Second end faces the bench, which may break the framing on purpose
    qsw_device i_qsw_device_b (.i_ref_clk(ref_clk), .i_reset_n(reset_n),
        .link(link_b), .o_wr_valid(valid_b), .o_wr_addr(waddr_b),
        .o_wr_data(wdata_b), .o_cmd_reject(rej_b));
    qsw_props i_qsw_props (.i_ref_clk(ref_clk), .i_reset_n(reset_n),
        .sclk(link_a.sclk), .chip_select_n(link_a.chip_select_n),
        .sio_oe(link_a.sio_oe), .serial_io_lines(link_a.serial_io_lines),
        .o_wr_valid(valid_a), .o_wr_addr(waddr_a), .o_wr_data(wdata_a),
        .o_cmd_reject(rej_a));
    // ==========
    // Clock, collectors and checks
    initial ref_clk = 1'b0;
    always #4 ref_clk = ~ref_clk;
    always @(posedge ref_clk)
    begin
        if (valid_a === 1'b1) got_a.push_back({waddr_a, wdata_a});
        if (valid_b === 1'b1) got_b.push_back({waddr_b, wdata_b});
        if (rej_b === 1'b1) rej_cnt++;
    end
    task automatic check_word(input logic [47:0] got, input logic [47:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[FAIL] %0t write %h expected %h", $time, got, exp);
        end
    endtask
    task automatic check_count(input int got, input int exp);
        total_checks++;
        if (got != exp)
        begin
            fail_count++;
            $display("[FAIL] %0t count %0d expected %0d", $time, got, exp);
        end
    endtask
    task automatic results;
        if (fail_count == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // ==========
    // Host end request, then every landed word compared
    task automatic host_write(input logic [15:0] a, input logic [31:0] d,
                              input logic [3:0] n);
        int k;
        got_a.delete();
        @(posedge ref_clk);
        start <= 1'b1;
        addr  <= a;
        data  <= d;
        words <= n;
        for (k = 0; k < 50 && busy !== 1'b1; k++) @(posedge ref_clk);
        start <= 1'b0;
        for (k = 0; k < 4000 && done !== 1'b1; k++) @(posedge ref_clk);
        check_count(int'({busy, done} === 2'b01), int'(n != 4'h0));
        repeat (12) @(posedge ref_clk);
        check_count(got_a.size(), n);
        for (k = 0; k < got_a.size(); k++)
            check_word(got_a[k], {a + 16'(4 * k), d});
    endtask
    // ==========
    // Bench frame at a 125 ns serial clock; released lines read high
    task automatic bb_case(input logic [7:0] c, input logic [15:0] a,
        input logic [31:0] d, input int nib, input int nw, input int nr);
        int j;
        got_b.delete();
        rej_cnt = 0;
        // Quarter-ns offset keeps every link edge off a reference edge
        #3.25 link_b.chip_select_n = 1'b0;
        for (int i = 0; i < 12 + nib; i++)
        begin
            link_b.sio_oe = (i < 8) ? 4'h1 : 4'hF;
            if (i < 8)
                link_b.sio_out = {3'h0, c[7 - i]};
            else if (i < 12)
                link_b.sio_out = a[15 - 4 * (i - 8) -: 4];
            else
                link_b.sio_out =
                    d[((i - 12) % 8) / 2 * 8 + 4 * (1 - i % 2) +: 4];
            #62.5 link_b.sclk = 1'b1;
            #62.5 link_b.sclk = 1'b0;
        end
        #31 link_b.chip_select_n = 1'b1;
        link_b.sio_oe = 4'h0;
        repeat (20) @(posedge ref_clk);
        check_count(got_b.size(), nw);
        check_count(rej_cnt, nr);
        for (j = 0; j < got_b.size(); j++)
            check_word(got_b[j], {a + 16'(4 * j), d});
    endtask
    initial
    begin
        #400000;
        fail_count++;
        results();
    end
    initial
    begin
        {reset_n, start, addr, data, words} = '0;
        {link_b.sclk, link_b.sio_out, link_b.sio_oe} = '0;
        link_b.chip_select_n = 1'b1;
        repeat (10) @(posedge ref_clk);
        reset_n <= 1'b1;
        host_write(16'h0123, 32'hA1B2C3D4, 4'h1);
        host_write(16'h1000, 32'h5A5AC3C3, 4'hF);
        host_write(16'h2000, 32'h11112222, 4'h0);
        host_write(16'h0002, 32'hFFFFFFFF, 4'h2);
        bb_case(8'hE2, 16'h0041, 32'h89ABCDEF, 8, 1, 0);
        bb_case(8'hE2, 16'h0200, 32'h0F1E2D3C, 16, 2, 0);
        bb_case(8'hE2, 16'h0300, 32'h12345678, 7, 0, 0);
        bb_case(8'hE2, 16'h0300, 32'h12345678, 15, 1, 0);
        foreach (bad_cmd[m])
            bb_case(bad_cmd[m], 16'h0400, 32'h0BAD0BAD, 8, 0, 1);
        results();
    end
endmodule // testbench
